// File: src/fdo_output_router.sv
`timescale 1ns/1ps
`default_nettype none

module fdo_output_router
(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    // function select write
    input  wire fdo_pkg::fdo_sel_wr_t  sel_wr,
    // bus-written words
    input  wire fdo_pkg::fdo_can_wr_t  can_wr,
    input  wire fdo_pkg::fdo_card_wr_t card_wr,
    input  wire fdo_pkg::fdo_rs_wr_t   rs_wr,
    // internal drive state
    input  wire logic [18:0]           drive_status,
    input  wire logic                  fire_input_a,
    input  wire logic                  fire_input_b,
    input  wire logic                  fire_mode_active,
    input  wire logic                  bypass_enabled,
    // readback of the stored words
    output logic [15:0]                can_obj_rdata,
    output logic [15:0]                card_word_rdata,
    // terminals
    output logic                       relay_out_one,
    output logic                       relay_out_two,
    output logic                       relay_out_three,
    output logic                       transistor_out_one,
    output logic                       transistor_out_two,
    output logic                       transistor_out_three,
    output logic                       transistor_out_four,
    output logic                       transistor_out_five,
    output logic                       transistor_out_six,
    output logic                       transistor_out_seven,
    output logic                       transistor_out_eight,
    output logic                       ext_transistor_out_a,
    output logic                       ext_transistor_out_b,
    output logic                       ext_relay_a,
    output logic                       ext_relay_b,
    output logic                       ext_relay_c,
    output logic                       ext_relay_d,
    output logic                       ext_relay_e,
    output logic                       ext_relay_f
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    localparam int N = fdo_pkg::NUM_TERM;

    logic [7:0]   sel_q [N];      // per-terminal function select
    logic [7:0]   sel_d [N];
    logic [15:0]  obj_q;          // fieldbus output object
    logic [15:0]  obj_d;
    logic [15:0]  card_q;         // card output word
    logic [15:0]  card_d;
    logic [N-1:0] rs_q;           // serial output command word
    logic [N-1:0] rs_d;
    logic [N-1:0] term_q;         // registered terminal levels
    logic [N-1:0] term_d;
    logic         fire_any;       // either fire input function on
    logic         fire_bypass;    // bypass enabled inside fire mode

    // ------------------------------------------------------------------
    // level decode, shared by every terminal
    // ------------------------------------------------------------------
    // codes other than the five decoded ones fall back to drive status, so a stray
    // bus bit can never reach such a terminal
    function automatic logic out_level(
        input logic [7:0] code,
        input logic       can_b,
        input logic       card_b,
        input logic       rs_b,
        input logic       st,
        input logic       fire,
        input logic       byp);
        logic lvl;
        lvl = st;
        case (code)
            fdo_pkg::CODE_CAN:    lvl = can_b;
            fdo_pkg::CODE_RS485:  lvl = rs_b;
            fdo_pkg::CODE_CARD:   lvl = card_b;
            fdo_pkg::CODE_FIRE:   lvl = fire;
            fdo_pkg::CODE_BYPASS: lvl = byp;
            default:              lvl = st;
        endcase
        return lvl;
    endfunction

    // ------------------------------------------------------------------
    // next state of selects and words
    // ------------------------------------------------------------------
    // each select has its own write decode
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            sel_d[i] = sel_q[i];
            if (sel_wr.wr && (sel_wr.idx == i[fdo_pkg::IDX_W-1:0]))
            begin
                sel_d[i] = sel_wr.code;
            end
        end
        obj_d  = obj_q;
        card_d = card_q;
        rs_d   = rs_q;
        // object written only on exact index and subindex
        if (can_wr.wr && (can_wr.index == fdo_pkg::CAN_OBJ_INDEX) &&
            (can_wr.sub == fdo_pkg::CAN_OBJ_SUB))
        begin
            obj_d = can_wr.data;
        end
        // card word written only at its address
        if (card_wr.wr && (card_wr.addr == fdo_pkg::CARD_ADDR))
        begin
            card_d = card_wr.data;
        end
        // serial commands, one bit per terminal
        if (rs_wr.wr)
        begin
            rs_d = rs_wr.data;
        end
    end

    // ------------------------------------------------------------------
    // terminal level per position
    // ------------------------------------------------------------------
    assign fire_any    = fire_input_a | fire_input_b;
    assign fire_bypass = fire_mode_active & bypass_enabled;

    generate
        for (genvar g = 0; g < N; g++)
        begin : g_term
            logic can_b;   // mapped object bit, zero where unmapped
            logic card_b;  // mapped card bit, zero where unmapped
            // shared extension positions read the same object bit
            assign can_b  = fdo_pkg::CAN_EN[g] &
                            obj_q[fdo_pkg::CAN_BIT[g]];
            assign card_b = fdo_pkg::CARD_EN[g] &
                            card_q[fdo_pkg::CARD_BIT[g]];
            assign term_d[g] = out_level(sel_q[g], can_b, card_b, rs_q[g],
                                         drive_status[g], fire_any,
                                         fire_bypass);
        end
    endgenerate

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // outputs lag a bus write by two edges: word, then terminal
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < N; i++)
            begin
                sel_q[i] <= fdo_pkg::SEL_RESET;
            end
            obj_q  <= fdo_pkg::WORD_RESET;
            card_q <= fdo_pkg::WORD_RESET;
            rs_q   <= fdo_pkg::TERM_RESET;
            term_q <= fdo_pkg::TERM_RESET;
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                sel_q[i] <= sel_d[i];
            end
            obj_q  <= obj_d;
            card_q <= card_d;
            rs_q   <= rs_d;
            term_q <= term_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign can_obj_rdata        = obj_q;
    assign card_word_rdata      = card_q;
    assign relay_out_one        = term_q[0];
    assign relay_out_two        = term_q[1];
    assign relay_out_three      = term_q[2];
    assign transistor_out_one   = term_q[3];
    assign transistor_out_two   = term_q[4];
    assign transistor_out_three = term_q[5];
    assign transistor_out_four  = term_q[6];
    assign transistor_out_five  = term_q[7];
    assign transistor_out_six   = term_q[8];
    assign transistor_out_seven = term_q[9];
    assign transistor_out_eight = term_q[10];
    assign ext_transistor_out_a = term_q[11];
    assign ext_transistor_out_b = term_q[12];
    assign ext_relay_a          = term_q[13];
    assign ext_relay_b          = term_q[14];
    assign ext_relay_c          = term_q[15];
    assign ext_relay_d          = term_q[16];
    assign ext_relay_e          = term_q[17];
    assign ext_relay_f          = term_q[18];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_can_relay_two;
        @(posedge ref_clk) disable iff (!resetn)
        can_wr.wr && can_wr.index == fdo_pkg::CAN_OBJ_INDEX &&
        can_wr.sub == fdo_pkg::CAN_OBJ_SUB && sel_q[1] == fdo_pkg::CODE_CAN
        && !sel_wr.wr
        |=> ##1 relay_out_two == $past(can_wr.data[1], 2);
    endproperty
    a_can_relay_two: assert property (p_can_relay_two)
        else $error("relay two misses object bit");

    property p_sel_isolated;
        @(posedge ref_clk) disable iff (!resetn)
        sel_wr.wr && sel_wr.idx == 5'h01 |=> $stable(sel_q[0]) &&
        $stable(sel_q[2]) && sel_q[1] == $past(sel_wr.code);
    endproperty
    a_sel_isolated: assert property (p_sel_isolated)
        else $error("relay two select disturbed a neighbour");

    property p_can_tr_two;
        @(posedge ref_clk) disable iff (!resetn)
        sel_q[4] == fdo_pkg::CODE_CAN |=> transistor_out_two == $past(obj_q[4]);
    endproperty
    a_can_tr_two: assert property (p_can_tr_two)
        else $error("transistor two not on object bit 4");

    property p_ext_shared;
        @(posedge ref_clk) disable iff (!resetn)
        sel_q[11] == fdo_pkg::CODE_CAN && sel_q[13] == fdo_pkg::CODE_CAN &&
        sel_q[18] == fdo_pkg::CODE_CAN
        |=> ext_transistor_out_a == ext_relay_a &&
            ext_relay_f == $past(obj_q[10]);
    endproperty
    a_ext_shared: assert property (p_ext_shared)
        else $error("extension mapping wrong");

    property p_rs485;
        @(posedge ref_clk) disable iff (!resetn)
        sel_q[5] == fdo_pkg::CODE_RS485
        |=> transistor_out_three == $past(rs_q[5]);
    endproperty
    a_rs485: assert property (p_rs485)
        else $error("serial command not followed");

    property p_card_decode;
        @(posedge ref_clk) disable iff (!resetn)
        card_wr.wr && card_wr.addr != fdo_pkg::CARD_ADDR |=> $stable(card_q);
    endproperty
    a_card_decode: assert property (p_card_decode)
        else $error("card word written at a wrong address");

    property p_card_tr_eight;
        @(posedge ref_clk) disable iff (!resetn)
        sel_q[10] == fdo_pkg::CODE_CARD
        |=> transistor_out_eight == $past(card_q[10]);
    endproperty
    a_card_tr_eight: assert property (p_card_tr_eight)
        else $error("transistor eight not on card bit 10");

    property p_bypass;
        @(posedge ref_clk) disable iff (!resetn)
        sel_q[2] == fdo_pkg::CODE_BYPASS
        |=> relay_out_three == $past(fire_mode_active && bypass_enabled);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass indication wrong");

    property p_fire;
        @(posedge ref_clk) disable iff (!resetn)
        sel_q[0] == fdo_pkg::CODE_FIRE
        |=> relay_out_one == $past(fire_input_a || fire_input_b);
    endproperty
    a_fire: assert property (p_fire)
        else $error("fire indication wrong");

    property p_status_fallback;
        @(posedge ref_clk) disable iff (!resetn)
        sel_q[6] == fdo_pkg::SEL_RESET
        |=> transistor_out_four == $past(drive_status[6]);
    endproperty
    a_status_fallback: assert property (p_status_fallback)
        else $error("non-communication terminal took a bus bit");

endmodule

`default_nettype wire

// File: shared/fdo_pkg.sv
`default_nettype none

package fdo_pkg;

    // ------------------------------------------------------------------
    // terminal set
    // ------------------------------------------------------------------
    // order: relays 1-3, transistors 1-8, ext transistors a-b, ext relays a-f
    localparam int NUM_TERM  = 19;
    localparam int IDX_W     = 5;
    localparam int CODE_W    = 8;
    localparam int WORD_W    = 16;
    localparam int BITPOS_W  = 4;

    // ------------------------------------------------------------------
    // function select codes
    // ------------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE_CAN    = 8'h32; // 50
    localparam logic [CODE_W-1:0] CODE_RS485  = 8'h33; // 51
    localparam logic [CODE_W-1:0] CODE_CARD   = 8'h34; // 52
    localparam logic [CODE_W-1:0] CODE_FIRE   = 8'h35; // 53
    localparam logic [CODE_W-1:0] CODE_BYPASS = 8'h36; // 54
    localparam logic [CODE_W-1:0] SEL_RESET   = 8'h00;

    // ------------------------------------------------------------------
    // addressing of the bus-written words
    // ------------------------------------------------------------------
    localparam logic [15:0] CAN_OBJ_INDEX = 16'h2026;
    localparam logic [7:0]  CAN_OBJ_SUB   = 8'h41;
    localparam logic [15:0] CARD_ADDR     = 16'h2640;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    localparam logic [NUM_TERM-1:0] TERM_RESET = 19'h00000;

    // ------------------------------------------------------------------
    // bit maps per terminal
    // ------------------------------------------------------------------
    localparam logic [NUM_TERM-1:0] CAN_EN  = 19'h7f81b;
    localparam logic [NUM_TERM-1:0] CARD_EN = 19'h007ff;
    localparam logic [BITPOS_W-1:0] CAN_BIT [NUM_TERM] = '{
        4'h0, 4'h1, 4'h0, 4'h3, 4'h4, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
        4'h0, 4'h5, 4'h6, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};
    localparam logic [BITPOS_W-1:0] CARD_BIT [NUM_TERM] = '{
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
        4'ha, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              wr;
        logic [IDX_W-1:0]  idx;
        logic [CODE_W-1:0] code;
    } fdo_sel_wr_t;

    typedef struct packed {
        logic              wr;
        logic [15:0]       index;
        logic [7:0]        sub;
        logic [WORD_W-1:0] data;
    } fdo_can_wr_t;

    typedef struct packed {
        logic              wr;
        logic [15:0]       addr;
        logic [WORD_W-1:0] data;
    } fdo_card_wr_t;

    typedef struct packed {
        logic                wr;
        logic [NUM_TERM-1:0] data;
    } fdo_rs_wr_t;

endpackage

`default_nettype wire

// File: sim/fdo_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// network master: writes the bus words toward the router
// ----------------------------------------------------------------------
module fdo_master_model
(
    // clock
    input  wire logic                  ref_clk,
    // bus writes toward the router
    output var  fdo_pkg::fdo_can_wr_t  can_wr,
    output var  fdo_pkg::fdo_card_wr_t card_wr,
    output var  fdo_pkg::fdo_rs_wr_t   rs_wr
);

    // quiet bus at time zero
    initial
    begin
        can_wr  = '0;
        card_wr = '0;
        rs_wr   = '0;
    end

    // one-cycle write; released lines show the inverse, never a stale copy
    task automatic can_write(input logic [15:0] index,
                             input logic [7:0] sub,
                             input logic [15:0] data);
        @(negedge ref_clk);
        can_wr <= '{wr: 1'b1, index: index, sub: sub, data: data};
        @(negedge ref_clk);
        can_wr <= '{wr: 1'b0, index: ~index, sub: ~sub, data: ~data};
    endtask

    // card register write, same shape
    task automatic card_write(input logic [15:0] addr,
                              input logic [15:0] data);
        @(negedge ref_clk);
        card_wr <= '{wr: 1'b1, addr: addr, data: data};
        @(negedge ref_clk);
        card_wr <= '{wr: 1'b0, addr: ~addr, data: ~data};
    endtask

    // serial command word, one bit a terminal
    task automatic rs_write(input logic [18:0] data);
        @(negedge ref_clk);
        rs_wr <= '{wr: 1'b1, data: data};
        @(negedge ref_clk);
        rs_wr <= '{wr: 1'b0, data: ~data};
    endtask

endmodule

`default_nettype wire

// File: sim/fdo_output_router_bench.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// bench for the output router
// ----------------------------------------------------------------------
module fdo_output_router_bench;

    // fieldbus bit per terminal, -1 where unmapped
    localparam int CAN_POS [19] = '{0, 1, -1, 3, 4, -1, -1, -1, -1, -1,
                                    -1, 5, 6, 5, 6, 7, 8, 9, 10};

    logic                  ref_clk;      // 40 MHz
    logic                  resetn;       // async, active low
    fdo_pkg::fdo_sel_wr_t  sel_wr;       // select writes
    fdo_pkg::fdo_can_wr_t  can_wr;       // from master model
    fdo_pkg::fdo_card_wr_t card_wr;      // from master model
    fdo_pkg::fdo_rs_wr_t   rs_wr;        // from master model
    logic [18:0]           drive_status; // internal status
    logic [3:0]            fire;         // fire a, fire b, mode, bypass
    logic [15:0]           can_rd;       // object readback
    logic [15:0]           card_rd;      // card readback
    wire logic [18:0]      term;         // terminals in index order
    int                    n_errors;
    int                    n_checks;
    int                    n_cycles;     // hang guard

    fdo_master_model master
    (
        .ref_clk(ref_clk), .can_wr(can_wr), .card_wr(card_wr), .rs_wr(rs_wr)
    );

    fdo_output_router dut
    (
        .ref_clk(ref_clk), .resetn(resetn), .sel_wr(sel_wr),
        .can_wr(can_wr), .card_wr(card_wr), .rs_wr(rs_wr),
        .drive_status(drive_status), .fire_input_a(fire[0]),
        .fire_input_b(fire[1]), .fire_mode_active(fire[2]),
        .bypass_enabled(fire[3]), .can_obj_rdata(can_rd),
        .card_word_rdata(card_rd),
        .relay_out_one(term[0]), .relay_out_two(term[1]),
        .relay_out_three(term[2]), .transistor_out_one(term[3]),
        .transistor_out_two(term[4]), .transistor_out_three(term[5]),
        .transistor_out_four(term[6]), .transistor_out_five(term[7]),
        .transistor_out_six(term[8]), .transistor_out_seven(term[9]),
        .transistor_out_eight(term[10]), .ext_transistor_out_a(term[11]),
        .ext_transistor_out_b(term[12]), .ext_relay_a(term[13]),
        .ext_relay_b(term[14]), .ext_relay_c(term[15]),
        .ext_relay_d(term[16]), .ext_relay_e(term[17]),
        .ext_relay_f(term[18])
    );

    // free-running clock, 25 ns period
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // compare and count
    task automatic check(input logic [18:0] exp, input logic [18:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask

    // final report, the only way out
    task automatic print_verdict();
        $display("checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // write one function select
    task automatic set_sel(input logic [4:0] idx, input logic [7:0] code);
        @(negedge ref_clk);
        sel_wr <= '{wr: 1'b1, idx: idx, code: code};
        @(negedge ref_clk);
        sel_wr <= '{wr: 1'b0, idx: 5'h1f, code: 8'hff};
    endtask

    // same code on every terminal
    task automatic set_all(input logic [7:0] code);
        for (int i = 0; i < 19; i++)
            set_sel(i[4:0], code);
    endtask

    // two edges: word stored, then terminal updated
    task automatic settle();
        repeat (2) @(negedge ref_clk);
    endtask

    // expected terminals for a fieldbus word
    function automatic logic [18:0] can_exp(input logic [15:0] w);
        logic [18:0] e;
        e = 19'h00000;
        for (int i = 0; i < 19; i++)
            if (CAN_POS[i] >= 0)
                e[i] = w[CAN_POS[i]];
        return e;
    endfunction

    // hang guard
    always @(posedge ref_clk)
    begin
        n_cycles++;
        if (n_cycles == 5000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    // main sequence
    initial
    begin
        logic [15:0] w;
        n_errors = 0;
        n_checks = 0;
        n_cycles = 0;
        resetn = 1'b0;
        sel_wr = '{wr: 1'b0, idx: 5'h00, code: 8'h00};
        drive_status = 19'h5a5a5;
        fire = 4'h0;
        repeat (4) @(negedge ref_clk);
        check(19'h00000, term);
        resetn = 1'b1;
        settle();
        // no comm code: status drives, bus bits ignored
        master.can_write(fdo_pkg::CAN_OBJ_INDEX, fdo_pkg::CAN_OBJ_SUB, 16'hffff);
        settle();
        check(19'h5a5a5, term);
        // relay two alone under fieldbus control
        drive_status = 19'h00000;
        set_sel(5'h01, 8'h32);
        master.can_write(fdo_pkg::CAN_OBJ_INDEX, fdo_pkg::CAN_OBJ_SUB, 16'hfffd);
        settle();
        check(19'h00000, term);
        master.can_write(fdo_pkg::CAN_OBJ_INDEX, fdo_pkg::CAN_OBJ_SUB, 16'h0002);
        settle();
        check(19'h00002, term);
        // every terminal on the fieldbus object, one bit at a time
        set_all(8'h32);
        for (int b = 0; b < 16; b++)
        begin
            w = 16'h0001 << b;
            master.can_write(fdo_pkg::CAN_OBJ_INDEX, fdo_pkg::CAN_OBJ_SUB, w);
            settle();
            check({3'h0, w}, {3'h0, can_rd});
            check(can_exp(w), term);
        end
        // wrong sub-index or index is dropped
        master.can_write(16'h2026, 8'h40, 16'h0000);
        master.can_write(16'h2027, 8'h41, 16'h0000);
        settle();
        check(19'h08000, {3'h0, can_rd});
        // card register, one bit at a time
        set_all(8'h34);
        for (int b = 0; b < 16; b++)
        begin
            w = 16'h0001 << b;
            master.card_write(fdo_pkg::CARD_ADDR, w);
            settle();
            check({3'h0, w}, {3'h0, card_rd});
            check({8'h00, w[10:0]}, term);
        end
        master.card_write(16'h2641, 16'h0000);
        settle();
        check(19'h08000, {3'h0, card_rd});
        // serial commands, a pattern and its inverse
        set_all(8'h33);
        master.rs_write(19'h5a5a5);
        settle();
        check(19'h5a5a5, term);
        master.rs_write(19'h25a5a);
        settle();
        check(19'h25a5a, term);
        // fire indication: either input
        set_all(8'h35);
        for (int k = 0; k < 4; k++)
        begin
            fire = {2'h0, k[1:0]};
            settle();
            check({19{k != 0}}, term);
        end
        // bypass indication: needs fire mode and bypass together
        set_all(8'h36);
        for (int k = 0; k < 4; k++)
        begin
            fire = {k[1:0], 2'h3};
            settle();
            check({19{k == 3}}, term);
        end
        // reset in mid-run clears words and terminals
        resetn = 1'b0;
        @(negedge ref_clk);
        check(19'h00000, term);
        check(19'h00000, {3'h0, can_rd | card_rd});
        resetn = 1'b1;
        print_verdict();
    end

endmodule

`default_nettype wire
